// ### spio_pkg.sv
/*
  Shared parallel I/O port package: register map, reset values, bus carriers.
  Assumes a single core clock domain and an AXI4-Lite register master.
*/
`default_nettype none
package spio_pkg;
  // Port geometry
  localparam int NPORT = 5;
  localparam int PW = 16;
  // Register word indices, byte address four times these: direction, level, latch per port
  localparam logic [11:0] PORT_BASE = 12'h2C6;
  localparam logic [11:0] PORT_STRIDE = 12'h006;
  localparam logic [11:0] OFS_DIR = 12'h000;
  localparam logic [11:0] OFS_LVL = 12'h002;
  localparam logic [11:0] OFS_LAT = 12'h004;
  // Analog pin configuration register, word aligned at an offset of our own
  localparam logic [11:0] ANALOG_CFG_OFS = 12'h300;
  // Implemented bit masks per port (ports B..F)
  localparam logic [NPORT*PW-1:0] IMPL_MASK = {16'h000C, 16'h013F, 16'h0003, 16'hE000, 16'h003F};
  // Reset values
  localparam logic [PW-1:0] LAT_RST = 16'h0000;
  localparam logic [PW-1:0] ANALOG_RST = 16'h0000;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Register selectors
  typedef enum logic [1:0] {
    SPIO_SEL_DIR = 2'b00,
    SPIO_SEL_LVL = 2'b01,
    SPIO_SEL_LAT = 2'b10,
    SPIO_SEL_NONE = 2'b11
  } spio_sel_t;
  // Decoded register access
  typedef struct packed {
    logic hit;
    logic analog;
    logic [2:0] port;
    spio_sel_t sel;
  } spio_dec_t;
  // Per-port pad side bundle
  typedef struct packed {
    logic [PW-1:0] o;
    logic [PW-1:0] oe;
  } spio_pad_t;
endpackage : spio_pkg
`default_nettype wire

// ### spio_sync.sv
/*
  Two-flop synchroniser bank for asynchronous pad levels.
  Assumes the inputs may change at any time relative to core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module spio_sync #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;
endmodule : spio_sync
`default_nettype wire

// ### spio_pad_mux.sv
/*
  Output ownership multiplexer pair for one port's pads.
  Assumes peripheral enables come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module spio_pad_mux (
  // Port side
  input wire logic [15:0] port_o,
  input wire logic [15:0] port_oe,
  // Peripheral side
  input wire logic [15:0] periph_drive,
  input wire logic [15:0] periph_o,
  // Pad side
  output logic [15:0] pad_o,
  output logic [15:0] pad_oe
);
  // Peripheral wins where it drives, otherwise the port owns the pad
  assign pad_o = (periph_drive & periph_o) | (~periph_drive & port_o);
  assign pad_oe = periph_drive | port_oe;
endmodule : spio_pad_mux
`default_nettype wire

// ### spio_top.sv
/*
  Shared parallel I/O ports B..F with AXI4-Lite register access.
  Assumes pads are asynchronous, peripherals and bus share core_clk.
*/
// The AXI4-Lite register port and the register offsets were decided locally.
// Operation
// - Actively driving peripheral disables the port output driver; pin still readable.
// - Enabled but idle peripheral lets the port drive the pin.
// - Direction bit 1 means input with driver off, 0 means output.
// - Any reset sets all implemented direction bits to input.
// - Latch register reads the latch and writes the latch.
// - Level register reads sampled pins; writing it stores into the latch.
// - Unimplemented bits read zero in latch, direction and level.
// - Input-only shared pins are plain port pins driven only by the port.
// - Per pad, multiplexer pair gives peripheral priority for data and enable.
// - Analog-configured pins read zero from the level register.
`timescale 1ns/1ps
`default_nettype none
module spio_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // AXI4-Lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pads, five ports of sixteen bits
  input wire logic [spio_pkg::NPORT*16-1:0] pad_i,
  output logic [spio_pkg::NPORT*16-1:0] pad_o,
  output logic [spio_pkg::NPORT*16-1:0] pad_oe,
  // Shared peripherals
  input wire logic [spio_pkg::NPORT*16-1:0] periph_drive,
  input wire logic [spio_pkg::NPORT*16-1:0] periph_o,
  // Analog selection seen by the converter
  output logic [15:0] analog_pin_sel
);
  localparam int NP = spio_pkg::NPORT;

  // Address decode shared by read and write channels
  function automatic spio_pkg::spio_dec_t dec(input logic [11:0] a);
    spio_pkg::spio_dec_t d;
    logic [11:0] idx;
    logic [11:0] rel;
    d = '0;
    d.sel = spio_pkg::SPIO_SEL_NONE;
    // Offsets are word indices; the byte address on the bus is four times the index
    idx = {2'b00, a[11:2]};
    rel = idx - spio_pkg::PORT_BASE;
    if (a[1:0] != 2'b00) begin
      // A byte address inside a word decodes to nothing and answers with an error
      d.hit = 1'b0;
    end else if (idx == spio_pkg::ANALOG_CFG_OFS) begin
      d.hit = 1'b1;
      d.analog = 1'b1;
    end else begin
      for (int p = 0; p < NP; p++) begin
        if (rel == 12'(p) * spio_pkg::PORT_STRIDE + spio_pkg::OFS_DIR) begin
          d.hit = 1'b1;
          d.port = 3'(p);
          d.sel = spio_pkg::SPIO_SEL_DIR;
        end else if (rel == 12'(p) * spio_pkg::PORT_STRIDE + spio_pkg::OFS_LVL) begin
          d.hit = 1'b1;
          d.port = 3'(p);
          d.sel = spio_pkg::SPIO_SEL_LVL;
        end else if (rel == 12'(p) * spio_pkg::PORT_STRIDE + spio_pkg::OFS_LAT) begin
          d.hit = 1'b1;
          d.port = 3'(p);
          d.sel = spio_pkg::SPIO_SEL_LAT;
        end
      end
    end
    return d;
  endfunction : dec

  // Byte lanes of the low halfword that a write may change
  // Lanes two and three carry no register bits and are ignored
  function automatic logic [15:0] lane_mask(input logic [3:0] s);
    return {{8{s[1]}}, {8{s[0]}}};
  endfunction : lane_mask

  // Port state
  // Direction, latch and analog registers; level views are combinational
  logic [15:0] pin_direction_reg_r [NP];
  logic [15:0] output_latch_reg_r [NP];
  logic [15:0] analog_pin_config_reg_r;
  logic [15:0] pin_sync [NP];
  logic [15:0] pin_level [NP];

  // Write channel state
  // Address and data are parked until both halves have arrived
  logic aw_held_r;
  logic w_held_r;
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic do_write;
  spio_pkg::spio_dec_t wdec;
  logic [15:0] wval;
  logic [15:0] wmask;
  logic wr_dir;
  logic wr_lat;
  logic wr_ana;

  // Read channel state
  // Read value is decoded in the cycle the address is taken
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  spio_pkg::spio_dec_t rdec;
  logic [15:0] rval;

  // Per-port pad logic, sampling and ownership
  for (genvar g = 0; g < NP; g++) begin : g_port
    logic [15:0] mask;
    logic [15:0] port_oe;
    assign mask = spio_pkg::IMPL_MASK[g*16 +: 16];
    // Pad levels are asynchronous: two flops before anything reads them
    spio_sync #(.W(16)) u_sync (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .d(pad_i[g*16 +: 16]),
      .q(pin_sync[g])
    );
    // Level view: unimplemented and analog pins read zero; analog ports are port B
    if (g == 0) begin : g_an
      assign pin_level[g] = pin_sync[g] & mask & ~analog_pin_config_reg_r;
    end else begin : g_dig
      assign pin_level[g] = pin_sync[g] & mask;
    end
    // Direction 0 drives; input-only shared pins see only the port here
    assign port_oe = ~pin_direction_reg_r[g] & mask;
    spio_pad_mux u_mux (
      .port_o(output_latch_reg_r[g] & mask),
      .port_oe(port_oe),
      .periph_drive(periph_drive[g*16 +: 16] & mask),
      .periph_o(periph_o[g*16 +: 16]),
      .pad_o(pad_o[g*16 +: 16]),
      .pad_oe(pad_oe[g*16 +: 16])
    );
  end

  // Converter sees the analog selection straight from its register
  assign analog_pin_sel = analog_pin_config_reg_r;

  // Write address and data are taken independently, in either order
  // A held half refuses a second one until the register has been written and its response taken
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign do_write = aw_held_r && w_held_r && !bvalid_r;
  assign wdec = dec(aw_addr_r);
  assign wval = w_data_r[15:0];
  // Bits this write may change: strobed byte lanes, implemented pins only
  assign wmask = lane_mask(w_strb_r) & spio_pkg::IMPL_MASK[wdec.port*16 +: 16];
  // One strobe per register so each process below owns a single concern
  assign wr_dir = do_write && wdec.hit && !wdec.analog &&
    (wdec.sel == spio_pkg::SPIO_SEL_DIR);
  assign wr_lat = do_write && wdec.hit && !wdec.analog &&
    (wdec.sel == spio_pkg::SPIO_SEL_LVL || wdec.sel == spio_pkg::SPIO_SEL_LAT);
  assign wr_ana = do_write && wdec.hit && wdec.analog;

  // Capture write address
  // The address waits here until its data arrives, in either order
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end
  end

  // Capture write data
  // Strobes travel with the data so a late address still sees them
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      w_held_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end
  end

  // Direction bits: reset makes every implemented pin an input
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      for (int p = 0; p < NP; p++) begin
        pin_direction_reg_r[p] <= spio_pkg::IMPL_MASK[p*16 +: 16];
      end
    end else if (wr_dir) begin
      pin_direction_reg_r[wdec.port] <= (pin_direction_reg_r[wdec.port] & ~wmask) |
        (wval & wmask);
    end
  end

  // Output latch: level and latch writes both land here
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      for (int p = 0; p < NP; p++) begin
        output_latch_reg_r[p] <= spio_pkg::LAT_RST;
      end
    end else if (wr_lat) begin
      output_latch_reg_r[wdec.port] <= (output_latch_reg_r[wdec.port] & ~wmask) |
        (wval & wmask);
    end
  end

  // Analog selection: all sixteen bits stored, byte strobes honoured
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      analog_pin_config_reg_r <= spio_pkg::ANALOG_RST;
    end else if (wr_ana) begin
      analog_pin_config_reg_r <= (analog_pin_config_reg_r & ~lane_mask(w_strb_r)) |
        (wval & lane_mask(w_strb_r));
    end
  end

  // Write response, one cycle after both halves are held
  // An unmapped address still answers, with an error code and no effect
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      bvalid_r <= 1'b0;
      bresp_r <= spio_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r <= wdec.hit ? spio_pkg::RESP_OKAY : spio_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Response outputs straight from their flops
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // Read path: value selected by decoded register
  // Decode straight from the bus address; the answer is registered below
  assign rdec = dec(s_axi_araddr);
  always_comb begin
    rval = 16'h0000;
    if (rdec.analog) begin
      rval = analog_pin_config_reg_r;
    end else if (rdec.sel == spio_pkg::SPIO_SEL_DIR) begin
      rval = pin_direction_reg_r[rdec.port];
    end else if (rdec.sel == spio_pkg::SPIO_SEL_LVL) begin
      rval = pin_level[rdec.port];
    end else if (rdec.sel == spio_pkg::SPIO_SEL_LAT) begin
      rval = output_latch_reg_r[rdec.port];
    end
  end

  // One read at a time: the next address waits until the answer is taken
  assign s_axi_arready = !rvalid_r;

  // Read data registered, answer one cycle after the address is taken
  // Unmapped reads answer zero with an error code
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rvalid_r <= 1'b0;
      rresp_r <= spio_pkg::RESP_OKAY;
      rdata_r <= 32'h00000000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rresp_r <= rdec.hit ? spio_pkg::RESP_OKAY : spio_pkg::RESP_SLVERR;
      rdata_r <= {16'h0000, rval};
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Read outputs straight from their flops
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
endmodule : spio_top
`default_nettype wire

// ### spio_top_asserts.sv
/*
  Checker for the shared I/O port: pad ownership, reset direction, bus timing.
  Assumes it is bound to spio_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module spio_top_check (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Pads and peripherals
  input wire logic [79:0] pad_o,
  input wire logic [79:0] pad_oe,
  input wire logic [79:0] periph_drive,
  input wire logic [79:0] periph_o
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  localparam logic [79:0] M = spio_pkg::IMPL_MASK;
  // Pad ownership
  a_oe_periph: assert property (((periph_drive & M) & ~pad_oe) == '0)
    else $error("peripheral pad not enabled");
  a_o_periph: assert property (((pad_o ^ periph_o) & periph_drive & M) == '0)
    else $error("peripheral data not on pad");
  a_oe_unimpl: assert property ((pad_oe & ~M) == '0)
    else $error("unimplemented pad driven");
  a_oe_reset: assert property (disable iff (1'b0) !rst_b |=> pad_oe == (periph_drive & M))
    else $error("pads not inputs after reset");
  a_oe_stable: assert property ($stable(periph_drive) && !$rose(s_axi_bvalid)
    |-> $stable(pad_oe))
    else $error("pad enable moved without cause");
  // Bus timing
  a_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_r_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_b_after: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response timing");
  // Main scenarios
  c_periph: cover property (|(periph_drive & M));
  c_port_out: cover property (|(pad_oe & ~periph_drive));
  c_err: cover property (s_axi_bvalid && s_axi_bresp == spio_pkg::RESP_SLVERR);
endmodule : spio_top_check
bind spio_top spio_top_check i_chk (.core_clk(core_clk), .rst_b(rst_b),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .pad_o(pad_o), .pad_oe(pad_oe),
  .periph_drive(periph_drive), .periph_o(periph_o));
`default_nettype wire

// ### spio_pad_model.sv
/*
  Pad cell model: the wire level seen back at each pad input.
  Assumes the bench picks the outside level of undriven pads.
*/
`timescale 1ns/1ps
`default_nettype none
module spio_pad_model (
  // Output buffer
  input wire logic [79:0] pad_o,
  input wire logic [79:0] pad_oe,
  // Outside level of a released pad
  input wire logic [79:0] ext_lvl,
  // Level at the input buffer
  output logic [79:0] pad_i
);
  // Driven pads echo their buffer, released ones take the outside level
  assign pad_i = (pad_oe & pad_o) | (~pad_oe & ext_lvl);
endmodule : spio_pad_model
`default_nettype wire

// ### spio_top_bench.sv
/*
  Self-checking bench: random register traffic and peripheral takeover.
  Assumes spio_top, spio_pad_model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module spio_top_bench;
  logic clk = 0, rst_b = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic awr, wrd, bv, arr, rv;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd_d;
  logic [3:0] ws = 4'hF;
  logic [1:0] bresp, rresp;
  logic [79:0] pad_i, pad_o, pad_oe, pd = 0, po = 0, ext = 0;
  logic [15:0] asel, ana_m, dir_m [5], lat_m [5];
  logic [33:0] rq [$];
  logic [1:0] bq [$];
  int fail_count = 0, n_checks = 0;
  spio_top i_spio_top (.core_clk(clk), .rst_b(rst_b), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_d),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .pad_i(pad_i), .pad_o(pad_o),
    .pad_oe(pad_oe), .periph_drive(pd), .periph_o(po), .analog_pin_sel(asel));
  spio_pad_model i_spio_pad_model (.pad_o(pad_o), .pad_oe(pad_oe), .ext_lvl(ext), .pad_i(pad_i));
  // Clock
  initial forever #10 clk = ~clk;
  task automatic wrap_up;
    if (rq.size() != 0 || bq.size() != 0) fail_count++;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic cmp_r(input logic [33:0] g, input logic [33:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %0t read %h exp %h", $time, g, e);
    end
  endtask : cmp_r
  task automatic cmp_b(input logic [1:0] g, input logic [1:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %0t resp %h exp %h", $time, g, e);
    end
  endtask : cmp_b
  task automatic cmp_s(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %0t analog %h exp %h", $time, g, e);
    end
  endtask : cmp_s
  // Monitor: answers meet the oldest note
  always @(negedge clk) begin
    if (rv && rr) cmp_r({rresp, rd_d}, rq.pop_front());
    if (bv && br) cmp_b(bresp, bq.pop_front());
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ta, tw, tb;
    tb = 0;
    @(posedge clk);
    bq.push_back(e);
    awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
    while (!tb) begin
      @(negedge clk); ta = awv && awr; tw = wv && wrd; tb = bv;
      @(posedge clk); if (ta) awv <= 0; if (tw) wv <= 0; if (tb) br <= 0;
    end
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    logic ta, tr;
    tr = 0;
    @(posedge clk);
    rq.push_back(e);
    ara <= a; arv <= 1; rr <= 1;
    while (!tr) begin
      @(negedge clk); ta = arv && arr; tr = rv;
      @(posedge clk); if (ta) arv <= 0; if (tr) rr <= 0;
    end
  endtask : rd
  // Register indices become byte addresses four times larger
  function automatic logic [11:0] ba(logic [11:0] i);
    return {i[9:0], 2'b00};
  endfunction : ba
  function automatic logic [11:0] ad(int p, logic [11:0] o);
    return ba(spio_pkg::PORT_BASE + spio_pkg::PORT_STRIDE * 12'(p) + o);
  endfunction : ad
  function automatic logic [15:0] mk(int p);
    return spio_pkg::IMPL_MASK[p*16+:16];
  endfunction : mk
  // Expected pin level: peripheral first, then port, else outside level
  function automatic logic [15:0] lv(int p);
    logic [15:0] oe, o;
    oe = mk(p) & (pd[p*16+:16] | ~dir_m[p]);
    o = (pd[p*16+:16] & po[p*16+:16]) | (~pd[p*16+:16] & lat_m[p]);
    o = ((oe & o) | (~oe & ext[p*16+:16])) & mk(p);
    return (p == 0) ? (o & ~ana_m) : o;
  endfunction : lv
  task automatic chk(int p);
    repeat (3) @(posedge clk);
    cmp_s(asel, ana_m);
    rd(ad(p, spio_pkg::OFS_DIR), {18'h0, dir_m[p]});
    rd(ad(p, spio_pkg::OFS_LVL), {18'h0, lv(p)});
    rd(ad(p, spio_pkg::OFS_LAT), {18'h0, lat_m[p]});
  endtask : chk
  task automatic rst;
    rst_b <= 0;
    repeat (16) @(posedge clk);
    rst_b <= 1;
    for (int p = 0; p < 5; p++) begin
      dir_m[p] = mk(p);
      lat_m[p] = 16'h0000;
    end
    ana_m = 16'h0000;
    for (int p = 0; p < 5; p++) chk(p);
  endtask : rst
  function automatic logic [79:0] r80;
    return {16'($urandom), $urandom, $urandom};
  endfunction : r80
  // Main sequence
  initial begin
    int p, k;
    logic [31:0] d;
    logic [3:0] s;
    logic [15:0] sm;
    void'($urandom(32'hD4A5));
    ext = r80();
    rst();
    for (int i = 0; i < 40; i++) begin
      p = $urandom_range(4);
      k = $urandom_range(3);
      d = $urandom;
      s = 4'($urandom);
      sm = {{8{s[1]}}, {8{s[0]}}};
      ws <= s;
      pd <= r80() & r80();
      po <= r80();
      ext <= r80();
      if (k == 0 && p == 0) d[15:0] = d[15:0] | ana_m;
      case (k)
        0: wr(ad(p, spio_pkg::OFS_DIR), d, spio_pkg::RESP_OKAY);
        1: wr(ad(p, spio_pkg::OFS_LVL), d, spio_pkg::RESP_OKAY);
        2: wr(ad(p, spio_pkg::OFS_LAT), d, spio_pkg::RESP_OKAY);
        default: wr(ba(spio_pkg::ANALOG_CFG_OFS), d, spio_pkg::RESP_OKAY);
      endcase
      // Only strobed byte lanes change; unimplemented bits stay zero
      if (k == 0) dir_m[p] = (dir_m[p] & ~sm) | (d[15:0] & mk(p) & sm);
      else if (k < 3) lat_m[p] = (lat_m[p] & ~sm) | (d[15:0] & mk(p) & sm);
      else ana_m = (ana_m & ~sm) | (d[15:0] & sm);
      chk(p);
      rd(ba(spio_pkg::ANALOG_CFG_OFS), {18'h0, ana_m});
    end
    wr(12'h3F0, 32'hFFFF, spio_pkg::RESP_SLVERR);
    rd(12'h3F0, {spio_pkg::RESP_SLVERR, 32'h0});
    chk(0);
    rst();
    wrap_up();
  end
  // Watchdog
  initial begin
    #400000;
    fail_count++;
    wrap_up();
  end
endmodule : spio_top_bench
`default_nettype wire
